// ### rtl/efm_top.sv
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Descriptor buffer
// ----------------------------------------------------------------------
module efm_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import efm_pkg::*;

    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
            $error("efm_fifo needs a power of two depth of at least 2.");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } efm_fifo_state_type;

    efm_fifo_state_type q;
    efm_fifo_state_type d;
    logic push;
    logic pop;

    assign in_ready = (q.cnt != (PW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data = q.mem[q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

module efm_top #(
    parameter int NUM_EP = 4,
    parameter int NUM_ENT = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic in_tagged,
    input wire logic [efm_pkg::VID_W-1:0] in_vid,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(NUM_EP)-1:0] out_ep,
    output logic out_tagged,
    output logic [efm_pkg::VID_W-1:0] out_vid
);
    import efm_pkg::*;

    localparam int EPW = $clog2(NUM_EP);
    localparam int CW = $clog2(NUM_ENT + 1);
    localparam int DW = EPW + 1 + VID_W;

    initial begin
        if (NUM_EP < 2 || NUM_EP > REGION_WORDS || NUM_ENT < 1 ||
            NUM_EP * NUM_ENT > REGION_WORDS) begin
            $error("efm_top endpoint table does not fit its windows.");
        end
    end

    typedef struct packed {
        logic en;
        logic disc;
        logic [NUM_EP-1:0] ep_val;
        logic [NUM_EP-1:0][1:0] ep_mode;
        logic [NUM_EP-1:0][1:0] pr_cls;
        logic [NUM_EP-1:0][VID_W-1:0] pr_vid;
        logic [NUM_EP-1:0][NUM_ENT-1:0] ent_val;
        logic [NUM_EP-1:0][NUM_ENT-1:0][VID_W-1:0] ent_vid;
        logic [31:0] map_cnt;
        logic [31:0] drop_cnt;
        logic ap_wr;
        logic [ADDR_W-1:0] ap_addr;
        logic [31:0] rdata;
    } efm_state_type;

    efm_state_type q;
    efm_state_type d;

    // ------------------------------------------------------------------
    // Configuration check
    // ------------------------------------------------------------------
    logic [NUM_EP-1:0][1:0] own_cls;
    logic [EPW:0] n_valid;
    logic all_any;
    logic ut_any;
    logic sole_err;
    logic pair_err;
    logic cfg_err;
    logic cfg_ok;

    always_comb begin
        logic [CW-1:0] cnt;
        cnt = '0;
        n_valid = '0;
        all_any = 1'b0;
        ut_any = 1'b0;
        pair_err = 1'b0;
        cfg_err = 1'b0;
        for (int i = 0; i < NUM_EP; i++) begin
            cnt = '0;
            for (int j = 0; j < NUM_ENT; j++) begin
                if (q.ent_val[i][j] && q.ent_vid[i][j] >= VID_MIN &&
                    q.ent_vid[i][j] <= VID_MAX) begin
                    cnt = cnt + 1'b1;
                end
            end
            own_cls[i] = (cnt > CW'(1)) ? CLS_LIST2 : CLS_LIST1;
            if (q.ep_mode[i] == MODE_ALL) begin
                own_cls[i] = CLS_ALL;
            end else if (q.ep_mode[i] == MODE_UTPT) begin
                own_cls[i] = CLS_UTPT;
            end
            if (q.ep_val[i]) begin
                n_valid = n_valid + 1'b1;
                all_any = all_any || (q.ep_mode[i] == MODE_ALL);
                ut_any = ut_any || (q.ep_mode[i] == MODE_UTPT);
                if (!efm_pair_ok(own_cls[i], q.pr_cls[i])) begin
                    pair_err = 1'b1;
                end
                if (q.ep_mode[i] == 2'h3 ||
                    (q.ep_mode[i] == MODE_LIST && cnt == '0)) begin
                    cfg_err = 1'b1;
                end
            end
        end
    end

    assign sole_err = (all_any || ut_any) &&
                      n_valid > (EPW+1)'(1);
    assign cfg_ok = q.en && !sole_err && !pair_err && !cfg_err &&
                    n_valid != '0;

    // ------------------------------------------------------------------
    // Frame classification and endpoint match
    // ------------------------------------------------------------------
    logic cls_untag;
    logic cls_prio;
    logic cls_vlan;
    logic [NUM_EP-1:0] ep_hit;
    logic hit;
    logic [EPW-1:0] hit_idx;
    logic drop_resv;
    logic in_fire;
    logic push_v;
    logic push_tag;
    logic [VID_W-1:0] push_vid;
    logic fifo_ready;

    assign cls_untag = !in_tagged;
    assign cls_prio = in_tagged && in_vid == VID_PRIO;
    assign cls_vlan = in_tagged && in_vid != VID_PRIO;

    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < NUM_EP; i++) begin
            ep_hit[i] = 1'b0;
            if (q.ep_val[i]) begin
                case (q.ep_mode[i])
                    MODE_ALL: begin
                        ep_hit[i] = 1'b1;
                    end
                    MODE_UTPT: begin
                        ep_hit[i] = cls_untag || cls_prio;
                    end
                    MODE_LIST: begin
                        for (int j = 0; j < NUM_ENT; j++) begin
                            if (cls_vlan && q.ent_val[i][j] &&
                                in_vid <= VID_MAX &&
                                q.ent_vid[i][j] == in_vid) begin
                                ep_hit[i] = 1'b1;
                            end
                        end
                    end
                    default: begin
                        ep_hit[i] = 1'b0;
                    end
                endcase
            end
            if (ep_hit[i] && !hit) begin
                hit = 1'b1;
                hit_idx = EPW'(i);
            end
        end
    end

    assign drop_resv = q.disc && q.ep_mode[hit_idx] == MODE_ALL &&
                       cls_vlan && in_vid == VID_RESV;
    assign in_ready = fifo_ready;
    assign in_fire = in_valid && fifo_ready;
    assign push_v = in_fire && cfg_ok && hit && !drop_resv;

    // ------------------------------------------------------------------
    // Egress tag handling toward the peer endpoint
    // ------------------------------------------------------------------
    always_comb begin
        case (q.pr_cls[hit_idx])
            CLS_ALL: begin
                push_tag = in_tagged;
                push_vid = in_tagged ? in_vid : VID_PRIO;
            end
            CLS_UTPT: begin
                push_tag = 1'b0;
                push_vid = VID_PRIO;
            end
            CLS_LIST1: begin
                push_tag = 1'b1;
                push_vid = q.pr_vid[hit_idx];
            end
            CLS_LIST2: begin
                push_tag = 1'b1;
                push_vid = in_vid;
            end
            default: begin
                push_tag = 1'b0;
                push_vid = VID_PRIO;
            end
        endcase
    end

    efm_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(push_v),
        .in_ready(fifo_ready),
        .in_data({hit_idx, push_tag, push_vid}),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data({out_ep, out_tagged, out_vid})
    );

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic acc;
    logic [31:0] rd_val;

    assign acc = hsel && htrans[1] && hready;
    assign hreadyout = !(q.ap_wr && hsel && htrans[1] && !hwrite);
    assign hrdata = q.rdata;
    assign hresp = 1'b0;

    always_comb begin
        rd_val = '0;
        case (haddr[ADDR_W-1:0])
            OFS_CTRL: begin
                rd_val[CTRL_EN_BIT] = q.en;
                rd_val[CTRL_DISC_BIT] = q.disc;
            end
            OFS_STATUS: begin
                rd_val[ST_OK_BIT] = cfg_ok;
                rd_val[ST_SOLE_BIT] = sole_err;
                rd_val[ST_PAIR_BIT] = pair_err;
                rd_val[ST_CFG_BIT] = cfg_err;
            end
            OFS_MAP_CNT: begin
                rd_val = q.map_cnt;
            end
            OFS_DROP_CNT: begin
                rd_val = q.drop_cnt;
            end
            default: begin
                rd_val = '0;
            end
        endcase
        for (int i = 0; i < NUM_EP; i++) begin
            if (haddr[ADDR_W-1:0] == OFS_EP_BASE + ADDR_W'(i * 4)) begin
                rd_val[EP_VALID_BIT] = q.ep_val[i];
                rd_val[EP_MODE_LSB +: 2] = q.ep_mode[i];
                rd_val[EP_PEER_LSB +: 2] = q.pr_cls[i];
                rd_val[EP_PVID_LSB +: VID_W] = q.pr_vid[i];
            end
            for (int j = 0; j < NUM_ENT; j++) begin
                if (haddr[ADDR_W-1:0] ==
                    OFS_VID_BASE + ADDR_W'((i * NUM_ENT + j) * 4)) begin
                    rd_val[ENT_VALID_BIT] = q.ent_val[i][j];
                    rd_val[ENT_VID_LSB +: VID_W] = q.ent_vid[i][j];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State update
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.ap_wr = 1'b0;
        if (q.ap_wr) begin
            if (q.ap_addr == OFS_CTRL) begin
                d.en = hwdata[CTRL_EN_BIT];
                d.disc = hwdata[CTRL_DISC_BIT];
            end
            for (int i = 0; i < NUM_EP; i++) begin
                if (q.ap_addr == OFS_EP_BASE + ADDR_W'(i * 4)) begin
                    d.ep_val[i] = hwdata[EP_VALID_BIT];
                    d.ep_mode[i] = hwdata[EP_MODE_LSB +: 2];
                    d.pr_cls[i] = hwdata[EP_PEER_LSB +: 2];
                    d.pr_vid[i] = hwdata[EP_PVID_LSB +: VID_W];
                end
                for (int j = 0; j < NUM_ENT; j++) begin
                    if (q.ap_addr ==
                        OFS_VID_BASE + ADDR_W'((i * NUM_ENT + j) * 4)) begin
                        d.ent_val[i][j] = hwdata[ENT_VALID_BIT];
                        d.ent_vid[i][j] = hwdata[ENT_VID_LSB +: VID_W];
                    end
                end
            end
        end
        if (acc) begin
            d.ap_wr = hwrite;
            d.ap_addr = haddr[ADDR_W-1:0];
            if (!hwrite) begin
                d.rdata = rd_val;
            end
        end
        if (push_v) begin
            d.map_cnt = q.map_cnt + 32'h0000_0001;
        end else if (in_fire) begin
            d.drop_cnt = q.drop_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.map_cnt <= CNT_RST;
            q.drop_cnt <= CNT_RST;
            q.rdata <= RDATA_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_all_maps: assert property (@(posedge hclk)
        disable iff (!hresetn)
        in_fire && cfg_ok && all_any && !(q.disc && in_vid == VID_RESV)
        |-> push_v && q.ep_mode[hit_idx] == MODE_ALL)
        else $error("All-frames endpoint did not take a frame.");
    a_resv_kept: assert property (@(posedge hclk)
        disable iff (!hresetn)
        in_fire && cfg_ok && all_any && !q.disc && in_tagged &&
        in_vid == VID_RESV |=> q.map_cnt == $past(q.map_cnt) + 32'h1)
        else $error("Reserved VLAN ID frame was not mapped.");
    a_resv_drop: assert property (@(posedge hclk)
        disable iff (!hresetn)
        in_fire && cfg_ok && all_any && q.disc && in_tagged &&
        in_vid == VID_RESV |-> !push_v ##1 q.drop_cnt != $past(q.drop_cnt))
        else $error("Reserved VLAN ID frame was not discarded.");
    a_sole_ep: assert property (@(posedge hclk)
        disable iff (!hresetn)
        push_v |-> !((all_any || ut_any) && n_valid > (EPW+1)'(1)))
        else $error("Sole endpoint mode shared its interface.");
    a_pair_legal: assert property (@(posedge hclk)
        disable iff (!hresetn)
        push_v |-> efm_pair_ok(own_cls[hit_idx], q.pr_cls[hit_idx]))
        else $error("Frame passed an illegal endpoint pairing.");
    a_utpt_maps: assert property (@(posedge hclk)
        disable iff (!hresetn)
        in_fire && cfg_ok && ut_any && !cls_vlan |-> push_v)
        else $error("Untagged or priority frame was not mapped.");
    a_utpt_reject: assert property (@(posedge hclk)
        disable iff (!hresetn)
        push_v && q.ep_mode[hit_idx] == MODE_UTPT |-> !cls_vlan)
        else $error("VLAN-tagged frame mapped in untagged mode.");
    a_utpt_strip: assert property (@(posedge hclk)
        disable iff (!hresetn)
        push_v && q.pr_cls[hit_idx] == CLS_UTPT && fifo_ready &&
        !out_valid |=> out_valid && !out_tagged)
        else $error("Frame toward untagged endpoint kept a tag.");
    a_keep_tag: assert property (@(posedge hclk)
        disable iff (!hresetn)
        push_v && q.pr_cls[hit_idx] == CLS_ALL
        |-> push_tag == in_tagged && (!in_tagged || push_vid == in_vid))
        else $error("Tagging changed between all-frames endpoints.");
    a_list_tag: assert property (@(posedge hclk)
        disable iff (!hresetn)
        push_v && q.pr_cls[hit_idx] == CLS_LIST1
        |-> push_tag && push_vid == q.pr_vid[hit_idx])
        else $error("One-entry list peer did not get its VLAN ID.");
    a_list_keep: assert property (@(posedge hclk)
        disable iff (!hresetn)
        push_v && q.pr_cls[hit_idx] == CLS_LIST2
        |-> push_tag && push_vid == in_vid)
        else $error("Multi-entry list changed the VLAN ID.");
    a_list_only: assert property (@(posedge hclk)
        disable iff (!hresetn)
        push_v && q.ep_mode[hit_idx] == MODE_LIST |-> cls_vlan)
        else $error("List endpoint took an untagged frame.");
    a_unmapped: assert property (@(posedge hclk)
        disable iff (!hresetn)
        in_fire && !hit |-> !push_v ##1 q.map_cnt == $past(q.map_cnt))
        else $error("Unmapped frame was delivered.");
endmodule

// ### rtl/efm_pkg.sv
package efm_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int VID_W = 12;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_MAP_CNT = 12'h008;
    localparam logic [11:0] OFS_DROP_CNT = 12'h00c;
    localparam logic [11:0] OFS_EP_BASE = 12'h100;
    localparam logic [11:0] OFS_VID_BASE = 12'h200;
    localparam int REGION_WORDS = 64;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DISC_BIT = 1;
    localparam int ST_OK_BIT = 0;
    localparam int ST_SOLE_BIT = 1;
    localparam int ST_PAIR_BIT = 2;
    localparam int ST_CFG_BIT = 3;
    localparam int EP_VALID_BIT = 0;
    localparam int EP_MODE_LSB = 1;
    localparam int EP_PEER_LSB = 4;
    localparam int EP_PVID_LSB = 16;
    localparam int ENT_VALID_BIT = 15;
    localparam int ENT_VID_LSB = 0;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // VLAN ID values
    // ------------------------------------------------------------------
    localparam logic [11:0] VID_PRIO = 12'h000;
    localparam logic [11:0] VID_MIN = 12'h001;
    localparam logic [11:0] VID_MAX = 12'hffe;
    localparam logic [11:0] VID_RESV = 12'hfff;

    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------------
    // Modes and endpoint classes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_LIST = 2'b00,
        MODE_ALL = 2'b01,
        MODE_UTPT = 2'b10
    } efm_mode_type;

    typedef enum logic [1:0] {
        CLS_ALL = 2'b00,
        CLS_UTPT = 2'b01,
        CLS_LIST1 = 2'b10,
        CLS_LIST2 = 2'b11
    } efm_class_type;

    // Tells whether two endpoint classes may share one connection.
    function automatic logic efm_pair_ok(input logic [1:0] a,
                                         input logic [1:0] b);
        logic sa;
        logic sb;
        sa = (a == CLS_UTPT) || (a == CLS_LIST1);
        sb = (b == CLS_UTPT) || (b == CLS_LIST1);
        return (a == CLS_ALL && b == CLS_ALL) ||
               (a == CLS_LIST2 && b == CLS_LIST2) || (sa && sb);
    endfunction

endpackage

// ### verif/efm_peer.sv
`timescale 1ns/1ps

// ----
// Subscriber equipment model.
// ----
module efm_peer (
    input wire logic hclk,
    output logic in_valid,
    input wire logic in_ready,
    output logic in_tagged,
    output logic [11:0] in_vid,
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [1:0] out_ep,
    input wire logic out_tagged,
    input wire logic [11:0] out_vid,
    input wire logic hold,
    input wire logic slow
);
    logic [14:0] rx_q[$];
    int stuck = 0;
    initial begin
        in_valid = 1'b0;
        in_tagged = 1'b0;
        in_vid = 12'h000;
        out_ready = 1'b0;
    end
    always @(posedge hclk) begin
        out_ready <= !hold && (!slow || !out_ready);
        if (out_valid && out_ready) begin
            rx_q.push_back({out_ep, out_tagged, out_vid});
        end
    end
    task automatic send(input logic t, input logic [11:0] v);
        int n;
        n = 0;
        in_valid <= 1'b1;
        in_tagged <= t;
        in_vid <= t ? v : ~in_vid;
        do begin
            @(negedge hclk);
            n++;
        end while (in_ready !== 1'b1 && n < 100);
        if (n >= 100) begin
            stuck++;
        end
        @(posedge hclk);
        in_valid <= 1'b0;
        in_vid <= ~in_vid;
        @(posedge hclk);
    endtask
endmodule

// ### verif/efm_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_count++; $display("BAD %s exp %h got %h", n, e, g); end end

// ----
// Bench for the frame mapper.
// ----
module efm_top_tb;
    import efm_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, in_valid, in_ready, in_tagged;
    logic out_valid, out_ready, out_tagged;
    logic [11:0] in_vid, out_vid;
    logic [1:0] out_ep;
    int err_count = 0;
    int check_count = 0;

    always #12.5 hclk = ~hclk;

    efm_top u_efm_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready(hreadyout), .hwdata, .hreadyout, .hrdata,
        .hresp, .in_valid, .in_ready, .in_tagged, .in_vid, .out_valid,
        .out_ready, .out_ep, .out_tagged, .out_vid);
    efm_peer u_efm_peer (.hclk, .in_valid, .in_ready, .in_tagged, .in_vid,
        .out_valid, .out_ready, .out_ep, .out_tagged, .out_vid, .hold, .slow);

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic rdy_wait(output logic [31:0] d);
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            d = hrdata;
            n++;
            if (n > 50) begin
                err_count++;
                finish_test;
            end
        end while (hreadyout !== 1'b1);
        @(posedge hclk);
    endtask

    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        rdy_wait(d);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy_wait(d);
        `CHK("resp", 1'b0, hresp)
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task automatic rchk(input string n, input logic [11:0] a,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        `CHK(n, e, rd)
    endtask

    function automatic logic [31:0] epw(input logic [1:0] m, p,
        input logic [11:0] v);
        return 32'h1 | 32'(m) << EP_MODE_LSB | 32'(p) << EP_PEER_LSB |
            32'(v) << EP_PVID_LSB;
    endfunction

    function automatic logic [11:0] ea(input int i, j);
        return OFS_VID_BASE + 12'(4 * (i * 4 + j));
    endfunction

    task automatic clr;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_EP_BASE + 12'(4 * i), 32'h0);
            wr(ea(i / 2, i % 2), 32'h0);
        end
    endtask

    task automatic fexp(input logic [1:0] e, input logic t,
        input logic [11:0] v);
        int n;
        logic [14:0] f;
        n = 0;
        while (u_efm_peer.rx_q.size() == 0) begin
            @(posedge hclk);
            n++;
            if (n > 200) begin
                err_count++;
                finish_test;
            end
        end
        f = u_efm_peer.rx_q.pop_front();
        `CHK("frame", {e, t, v}, f)
    endtask

    task automatic snd(input logic t, input logic [11:0] v);
        u_efm_peer.send(t, v);
        if (u_efm_peer.stuck != 0) begin
            err_count++;
            finish_test;
        end
    endtask

    task automatic fx(input logic t, input logic [11:0] v,
        input logic [1:0] e, input logic et, input logic [11:0] ev);
        snd(t, v);
        fexp(e, et, ev);
    endtask

    task automatic nodrop(input logic t, input logic [11:0] v);
        snd(t, v);
        repeat (10) @(posedge hclk);
        `CHK("none", 0, u_efm_peer.rx_q.size())
    endtask

    localparam logic [15:0] POK = 16'h8661;

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("map", OFS_MAP_CNT, 32'h0);
        rchk("drop", OFS_DROP_CNT, 32'h0);
        rchk("hole", 12'h050, 32'h0);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_EP_BASE, epw(2'h1, 2'h0, 12'h0));
        rchk("st", OFS_STATUS, 32'h1);
        fx(1'b0, 12'h0, 2'h0, 1'b0, 12'h0);
        fx(1'b1, 12'h0, 2'h0, 1'b1, 12'h0);
        fx(1'b1, 12'h064, 2'h0, 1'b1, 12'h064);
        fx(1'b1, 12'hfff, 2'h0, 1'b1, 12'hfff);
        rchk("map", OFS_MAP_CNT, 32'h4);
        wr(OFS_CTRL, 32'h3);
        nodrop(1'b1, 12'hfff);
        rchk("drop", OFS_DROP_CNT, 32'h1);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_EP_BASE + 12'h4, epw(2'h0, 2'h2, 12'h00a));
        wr(ea(1, 0), 32'h800a);
        rchk("st", OFS_STATUS, 32'h2);
        nodrop(1'b0, 12'h0);
        wr(OFS_EP_BASE, epw(2'h2, 2'h2, 12'h00a));
        rchk("st", OFS_STATUS, 32'h2);
        clr;
        $display("all-frames and sole tests done");
        for (int c = 0; c < 4; c++) begin
            for (int p = 0; p < 4; p++) begin
                wr(ea(0, 0), c > 1 ? 32'h8007 : 32'h0);
                wr(ea(0, 1), c > 2 ? 32'h8008 : 32'h0);
                wr(OFS_EP_BASE, epw(c == 0 ? 2'h1 : c == 1 ? 2'h2 : 2'h0,
                    2'(p), 12'h00a));
                rchk("pair", OFS_STATUS,
                    POK[c*4+p] ? 32'h1 : 32'h4);
            end
        end
        clr;
        $display("pairing test done");
        wr(OFS_EP_BASE, epw(2'h2, 2'h2, 12'h02c));
        fx(1'b0, 12'h0, 2'h0, 1'b1, 12'h02c);
        fx(1'b1, 12'h0, 2'h0, 1'b1, 12'h02c);
        nodrop(1'b1, 12'h005);
        wr(OFS_EP_BASE, epw(2'h2, 2'h1, 12'h0));
        fx(1'b1, 12'h0, 2'h0, 1'b0, 12'h0);
        $display("untagged mode test done");
        wr(ea(0, 0), 32'h802d);
        wr(OFS_EP_BASE, epw(2'h0, 2'h2, 12'h065));
        fx(1'b1, 12'h02d, 2'h0, 1'b1, 12'h065);
        nodrop(1'b0, 12'h0);
        nodrop(1'b1, 12'h0);
        nodrop(1'b1, 12'h02e);
        wr(ea(0, 1), 32'h8008);
        wr(ea(1, 0), 32'h8009);
        wr(ea(1, 1), 32'h800a);
        wr(OFS_EP_BASE + 12'h4, epw(2'h0, 2'h3, 12'h0));
        wr(OFS_EP_BASE, epw(2'h0, 2'h3, 12'h0));
        fx(1'b1, 12'h008, 2'h0, 1'b1, 12'h008);
        fx(1'b1, 12'h00a, 2'h1, 1'b1, 12'h00a);
        fx(1'b1, 12'h02d, 2'h0, 1'b1, 12'h02d);
        $display("list mode test done");
        clr;
        wr(OFS_EP_BASE, epw(2'h1, 2'h0, 12'h0));
        hold <= 1'b1;
        for (int i = 1; i < 9; i++) begin
            snd(1'b1, 12'(i));
        end
        @(negedge hclk);
        `CHK("full", 1'b0, in_ready)
        @(posedge hclk);
        hold <= 1'b0;
        slow <= 1'b1;
        for (int i = 1; i < 9; i++) begin
            fexp(2'h0, 1'b1, 12'(i));
        end
        @(negedge hclk);
        `CHK("empty", 1'b1, in_ready)
        `CHK("stuck", 0, u_efm_peer.stuck)
        $display("buffer test done");
        finish_test;
    end
endmodule
